// [scrb_pkg.sv]
package scrb_pkg;
    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_REF_COUNTER = 8'h1F;
    localparam logic [7:0] ADDR_TEST_OUTPUT = 8'h20;
    localparam logic [7:0] ADDR_REF_PATH    = 8'h22;
    localparam logic [7:0] ADDR_FILTER_SRC  = 8'h23;
    localparam logic [7:0] ADDR_FEEDBACK    = 8'h24;
    localparam logic [7:0] ADDR_OUT_STAGE   = 8'h25;
    localparam logic [7:0] ADDR_FILTER_C0   = 8'h70;
    localparam logic [7:0] ADDR_FILTER_C1   = 8'h71;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_REF_COUNTER = 8'h01;
    localparam logic [7:0] RST_TEST_OUTPUT = 8'h14;
    localparam logic [7:0] RST_REF_PATH    = 8'h00;
    localparam logic [7:0] RST_FILTER_SRC  = 8'h00;
    localparam logic [7:0] RST_FEEDBACK    = 8'h80;
    localparam logic [7:0] RST_OUT_STAGE   = 8'h07;
    localparam logic [7:0] RST_FILTER_C    = 8'h00;

    // ************************************************************
    // writable bit masks; cleared bits are reserved and read zero
    // ************************************************************
    localparam logic [7:0] MASK_REF_COUNTER = 8'h1F;
    localparam logic [7:0] MASK_TEST_OUTPUT = 8'hFC;
    localparam logic [7:0] MASK_REF_PATH    = 8'h70;
    localparam logic [7:0] MASK_FILTER_SRC  = 8'h32;
    localparam logic [7:0] MASK_FEEDBACK    = 8'hF0;
    localparam logic [7:0] MASK_OUT_STAGE   = 8'hBF;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int REF_COUNT_MSB  = 4;
    localparam int TSEL_MSB       = 7;
    localparam int TSEL_LSB       = 4;
    localparam int TEN_BIT        = 3;
    localparam int LEVEL_BIT      = 2;
    localparam int REF_MODE_BIT   = 6;
    localparam int REF_DOUBLER_ENABLE_BIT   = 5;
    localparam int REF_HALF_BIT   = 4;
    localparam int FILTER_SEL_BIT = 1;
    localparam int FB_SRC_BIT     = 7;
    localparam int DIV_MSB        = 6;
    localparam int DIV_LSB        = 4;
    localparam int DIV_DB_BIT     = 5;
    localparam int X2_BIT         = 3;
    localparam int RF_OUTPUT_ENABLE_BIT      = 2;
    localparam int PWR_MSB        = 1;

    // ************************************************************
    // codes
    // ************************************************************
    localparam logic [3:0] TSEL_TRISTATE = 4'h0;
    localparam logic [3:0] TSEL_LOCK     = 4'h1;
    localparam logic [3:0] TSEL_PUMP_UP  = 4'h2;
    localparam logic [3:0] TSEL_PUMP_DN  = 4'h3;
    localparam logic [3:0] TSEL_REF_HALF = 4'h4;
    localparam logic [3:0] TSEL_FB_HALF  = 4'h5;
    localparam logic [3:0] TSEL_VCO_TEST = 4'h6;
    localparam logic [3:0] TSEL_HIGH     = 4'h8;
    localparam logic [3:0] TSEL_CAL_R    = 4'h9;
    localparam logic [3:0] TSEL_CAL_N    = 4'hA;
    localparam logic [2:0] DIV_RESERVED  = 3'h7;
    localparam logic [5:0] REF_DIV_ZERO  = 6'h20;
    localparam int         NUM_REGS      = 8;
endpackage

// [scrb_regmem.sv]
`timescale 1ns/10ps
`default_nettype none
// small register store with registered read data
module scrb_regmem #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          sys_clk,   // system clock
    input  wire logic          rst_n,     // sync reset, active low
    input  wire logic          wr_en,     // write strobe
    input  wire logic [AW-1:0] wr_idx,    // write slot
    input  wire logic [7:0]    wr_data,   // write data
    input  wire logic [7:0]    wr_mask,   // writable bits of slot
    input  wire logic [7:0]    rst_val,   // reset value of written slot
    input  wire logic [AW-1:0] rd_idx,    // read slot
    output logic      [7:0]    rd_data,   // registered read data
    output logic [DEPTH*8-1:0] all_data   // every slot, flat
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            rd;
    } scrb_mem_t;

    scrb_mem_t st;
    scrb_mem_t next_st;
    logic [DEPTH-1:0][7:0] rst_vals;

    // ************************************************************
    // reset image of every slot
    // ************************************************************
    always_comb
    begin
        rst_vals = '0;
        rst_vals[0] = scrb_pkg::RST_REF_COUNTER;
        rst_vals[1] = scrb_pkg::RST_TEST_OUTPUT;
        rst_vals[2] = scrb_pkg::RST_REF_PATH;
        rst_vals[3] = scrb_pkg::RST_FILTER_SRC;
        rst_vals[4] = scrb_pkg::RST_FEEDBACK;
        rst_vals[5] = scrb_pkg::RST_OUT_STAGE;
    end

    // masked write keeps reserved bits at zero
    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            next_st.mem[wr_idx] = (wr_data & wr_mask) | (rst_val & ~wr_mask);
        end
        next_st.rd = st.mem[rd_idx];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st.mem <= rst_vals;
            st.rd  <= 8'h00;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data  = st.rd;
    assign all_data = st.mem;
endmodule
`default_nettype wire

// [scrb_top.sv]
//
// Contract
// - Reference count divides by its value; zero divides by 32; resets to one.
// - Test select field bits 7:4 routes one source to the shared pin.
// - Select code zero tristates the pin, only while test enable is cleared and no serial read is in progress.
// - Enable clear: pin gives serial read data; set: pin carries selected signal.
// - Reference path bit 6 picks single-ended or differential input.
// - Reference path bit 5 enables the reference doubler.
// - Reference path bit 4 inserts a divide-by-two stage.
// - Filter source bit picks automatic or register-written coefficients.
// - Feedback bit 7 picks fundamental (one, default) or divided output.
// - Divide field bits 6:4 divides by 1..64; code 7 reserved; output stage bit 5 buffers.
// - Output enable bit 2 turns the output pair on; default on.
// - Power field bits 1:0 pick four levels; default three.
`timescale 1ns/10ps
`default_nettype none
module scrb_top (
    input  wire logic       sys_clk,              // 50 MHz clock
    input  wire logic       rst_n,                // sync reset, active low
    input  wire logic       reg_wr,               // register write strobe
    input  wire logic       reg_rd,               // register read strobe
    input  wire logic [7:0] reg_addr,             // register address
    input  wire logic [7:0] reg_wdata,            // write data
    output logic      [7:0] reg_rdata,            // read data, one cycle after reg_rd
    output logic            reg_rvalid,           // read data valid pulse
    input  wire logic       buffer_update,        // commit buffered settings pulse
    input  wire logic       spi_sdo,              // serial read data bit
    input  wire logic       spi_sdo_active,       // serial read in progress
    input  wire logic       lock_detect,          // test source
    input  wire logic       pump_up,              // test source
    input  wire logic       pump_down,            // test source
    input  wire logic       ref_div_half,         // test source
    input  wire logic       fb_div_half,          // test source
    input  wire logic       vco_test,             // test source
    input  wire logic       cal_r_half,           // test source
    input  wire logic       cal_n_half,           // test source
    output logic            test_pin_o,           // shared pin level
    output logic            test_pin_oe,          // shared pin drive enable
    output logic            output_level_select,  // pin logic level choice
    output logic      [5:0] ref_divide_ratio,     // effective reference ratio 1..32
    output logic            ref_input_mode,       // 1 differential
    output logic            ref_doubler_enable,   // reference doubler on
    output logic            ref_half_divide,      // divide-by-two stage
    output logic            filter_manual,        // use register coefficients
    output logic      [7:0] filter_coef0,         // manual coefficient 0
    output logic      [7:0] filter_coef1,         // manual coefficient 1
    output logic            feedback_source,      // 1 fundamental
    output logic      [6:0] out_divide_ratio,     // active output ratio
    output logic            output_doubler_enable,// output doubler on
    output logic            rf_output_enable,     // output pair on
    output logic            rf_out_pos_en,        // positive pin enable
    output logic            rf_out_neg_en,        // negative pin enable
    output logic      [1:0] output_power_level    // 0 lowest .. 3 highest
);
    typedef enum logic [1:0] {
        SCRB_PIN_SDO  = 2'b01,
        SCRB_PIN_TEST = 2'b10
    } scrb_pin_t;

    typedef struct packed {
        logic [2:0] div_active;
        logic       rvalid;
        scrb_pin_t  pin_mode;
        logic       pin_o;
        logic       pin_oe;
    } scrb_state_t;

    scrb_state_t st;
    scrb_state_t next_st;

    logic [3:0]  wr_idx;
    logic        wr_hit;
    logic [3:0]  rd_idx;
    logic        rd_hit;
    logic [7:0]  wr_mask;
    logic [7:0]  wr_rst;
    logic [7:0]  mem_rdata;
    logic [63:0] regs;
    logic [7:0]  r_ref, r_test, r_path, r_filt, r_fb, r_out, r_c0, r_c1;
    logic        test_sig;

    // ************************************************************
    // address decode
    // ************************************************************
    // map a register address to its store slot; unmapped gives hit low
    function automatic logic [3:0] slot_of(input logic [7:0] a);
        unique case (a)
            scrb_pkg::ADDR_REF_COUNTER: slot_of = 4'h8;
            scrb_pkg::ADDR_TEST_OUTPUT: slot_of = 4'h9;
            scrb_pkg::ADDR_REF_PATH:    slot_of = 4'hA;
            scrb_pkg::ADDR_FILTER_SRC:  slot_of = 4'hB;
            scrb_pkg::ADDR_FEEDBACK:    slot_of = 4'hC;
            scrb_pkg::ADDR_OUT_STAGE:   slot_of = 4'hD;
            scrb_pkg::ADDR_FILTER_C0:   slot_of = 4'hE;
            scrb_pkg::ADDR_FILTER_C1:   slot_of = 4'hF;
            default:                    slot_of = 4'h0;
        endcase
    endfunction

    // writable mask and reset value of a slot
    function automatic logic [7:0] mask_of(input logic [2:0] s);
        unique case (s)
            3'h0:    mask_of = scrb_pkg::MASK_REF_COUNTER;
            3'h1:    mask_of = scrb_pkg::MASK_TEST_OUTPUT;
            3'h2:    mask_of = scrb_pkg::MASK_REF_PATH;
            3'h3:    mask_of = scrb_pkg::MASK_FILTER_SRC;
            3'h4:    mask_of = scrb_pkg::MASK_FEEDBACK;
            3'h5:    mask_of = scrb_pkg::MASK_OUT_STAGE;
            default: mask_of = 8'hFF;
        endcase
    endfunction

    function automatic logic [7:0] rst_of(input logic [2:0] s);
        unique case (s)
            3'h0:    rst_of = scrb_pkg::RST_REF_COUNTER;
            3'h1:    rst_of = scrb_pkg::RST_TEST_OUTPUT;
            3'h4:    rst_of = scrb_pkg::RST_FEEDBACK;
            3'h5:    rst_of = scrb_pkg::RST_OUT_STAGE;
            default: rst_of = scrb_pkg::RST_FILTER_C;
        endcase
    endfunction

    assign wr_idx  = slot_of(reg_addr);
    assign wr_hit  = reg_wr & wr_idx[3];
    assign rd_idx  = slot_of(reg_addr);
    assign rd_hit  = rd_idx[3];
    assign wr_mask = mask_of(wr_idx[2:0]);
    assign wr_rst  = rst_of(wr_idx[2:0]);

    // ************************************************************
    // register store
    // ************************************************************
    scrb_regmem #(
        .DEPTH (scrb_pkg::NUM_REGS),
        .AW    (3)
    ) u_mem (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_hit),
        .wr_idx   (wr_idx[2:0]),
        .wr_data  (reg_wdata),
        .wr_mask  (wr_mask),
        .rst_val  (wr_rst),
        .rd_idx   (rd_idx[2:0]),
        .rd_data  (mem_rdata),
        .all_data (regs)
    );

    assign r_ref  = regs[7:0];
    assign r_test = regs[15:8];
    assign r_path = regs[23:16];
    assign r_filt = regs[31:24];
    assign r_fb   = regs[39:32];
    assign r_out  = regs[47:40];
    assign r_c0   = regs[55:48];
    assign r_c1   = regs[63:56];

    // ************************************************************
    // test source selection
    // ************************************************************
    // reserved codes drive low rather than float
    always_comb
    begin
        unique case (r_test[scrb_pkg::TSEL_MSB:scrb_pkg::TSEL_LSB])
            scrb_pkg::TSEL_LOCK:     test_sig = lock_detect;
            scrb_pkg::TSEL_PUMP_UP:  test_sig = pump_up;
            scrb_pkg::TSEL_PUMP_DN:  test_sig = pump_down;
            scrb_pkg::TSEL_REF_HALF: test_sig = ref_div_half;
            scrb_pkg::TSEL_FB_HALF:  test_sig = fb_div_half;
            scrb_pkg::TSEL_VCO_TEST: test_sig = vco_test;
            scrb_pkg::TSEL_HIGH:     test_sig = 1'b1;
            scrb_pkg::TSEL_CAL_R:    test_sig = cal_r_half;
            scrb_pkg::TSEL_CAL_N:    test_sig = cal_n_half;
            default:                 test_sig = 1'b0;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        next_st.rvalid = reg_rd;
        // pin ownership follows the enable bit
        if (r_test[scrb_pkg::TEN_BIT])
        begin
            next_st.pin_mode = SCRB_PIN_TEST;
        end
        else
        begin
            next_st.pin_mode = SCRB_PIN_SDO;
        end
        unique case (next_st.pin_mode)
            SCRB_PIN_TEST:
            begin
                next_st.pin_o  = test_sig;
                next_st.pin_oe = 1'b1;
            end
            SCRB_PIN_SDO:
            begin
                next_st.pin_o = spi_sdo;
                // code zero floats the pin outside serial reads
                next_st.pin_oe = spi_sdo_active |
                    (r_test[scrb_pkg::TSEL_MSB:scrb_pkg::TSEL_LSB] != scrb_pkg::TSEL_TRISTATE);
            end
            default:
            begin
                next_st.pin_o  = 1'b0;
                next_st.pin_oe = 1'b0;
            end
        endcase
        // divide ratio follows writes directly unless buffered
        if (!r_out[scrb_pkg::DIV_DB_BIT] || buffer_update)
        begin
            next_st.div_active = r_fb[scrb_pkg::DIV_MSB:scrb_pkg::DIV_LSB];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st.div_active <= 3'h0;
            st.rvalid     <= 1'b0;
            st.pin_mode   <= SCRB_PIN_SDO;
            st.pin_o      <= 1'b0;
            st.pin_oe     <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // unmapped reads return zero
    assign reg_rdata  = rd_hit ? mem_rdata : 8'h00;
    assign reg_rvalid = st.rvalid;
    assign test_pin_o  = st.pin_o;
    assign test_pin_oe = st.pin_oe;
    assign output_level_select = r_test[scrb_pkg::LEVEL_BIT];

    // zero count means the longest ratio
    assign ref_divide_ratio = (r_ref[scrb_pkg::REF_COUNT_MSB:0] == 5'h00) ?
        scrb_pkg::REF_DIV_ZERO : {1'b0, r_ref[scrb_pkg::REF_COUNT_MSB:0]};

    assign ref_input_mode     = r_path[scrb_pkg::REF_MODE_BIT];
    assign ref_doubler_enable = r_path[scrb_pkg::REF_DOUBLER_ENABLE_BIT];
    assign ref_half_divide    = r_path[scrb_pkg::REF_HALF_BIT];
    assign filter_manual      = r_filt[scrb_pkg::FILTER_SEL_BIT];
    assign filter_coef0       = r_c0;
    assign filter_coef1       = r_c1;
    assign feedback_source    = r_fb[scrb_pkg::FB_SRC_BIT];

    // reserved code holds the ratio at zero so downstream can ignore it
    assign out_divide_ratio = (st.div_active == scrb_pkg::DIV_RESERVED) ?
        7'h00 : 7'(7'h01 << st.div_active);

    assign output_doubler_enable = r_out[scrb_pkg::X2_BIT];
    assign rf_output_enable      = r_out[scrb_pkg::RF_OUTPUT_ENABLE_BIT];
    assign rf_out_pos_en         = r_out[scrb_pkg::RF_OUTPUT_ENABLE_BIT];
    assign rf_out_neg_en         = r_out[scrb_pkg::RF_OUTPUT_ENABLE_BIT];
    assign output_power_level    = r_out[scrb_pkg::PWR_MSB:0];
endmodule
`default_nettype wire

// [scrb_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// register bank checker
// ************************************************************
module scrb_chk (
    input wire logic       sys_clk,            // clock
    input wire logic       rst_n,              // sync reset, active low
    input wire logic       reg_wr,             // write strobe
    input wire logic       reg_rd,             // read strobe
    input wire logic [7:0] reg_addr,           // register address
    input wire logic [7:0] reg_wdata,          // write data
    input wire logic [7:0] reg_rdata,          // read data
    input wire logic       reg_rvalid,         // read data valid
    input wire logic       buffer_update,      // commit pulse
    input wire logic       spi_sdo,            // serial read bit
    input wire logic       spi_sdo_active,     // serial read running
    input wire logic       lock_detect,        // test source
    input wire logic       test_pin_o,         // shared pin level
    input wire logic       test_pin_oe,        // shared pin enable
    input wire logic [5:0] ref_divide_ratio,   // reference ratio
    input wire logic       feedback_source,    // feedback choice
    input wire logic [6:0] out_divide_ratio,   // output ratio
    input wire logic       rf_output_enable,   // output pair on
    input wire logic       rf_out_pos_en,      // positive pin on
    input wire logic       rf_out_neg_en,      // negative pin on
    input wire logic [1:0] output_power_level  // power code
);
    logic [7:0] sh_test;
    logic [2:0] sh_code;
    logic       sh_db;
    logic       mapped;

    // shadows of the registers the pin and divider depend on; reset mirrors the defaults
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sh_test <= 8'h14;
            sh_code <= 3'h0;
            sh_db   <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == 8'h20) sh_test <= reg_wdata;
            if (reg_addr == 8'h24) sh_code <= reg_wdata[6:4];
            if (reg_addr == 8'h25) sh_db <= reg_wdata[5];
        end
    end

    // address decode for the refusal check
    always_comb mapped = reg_addr inside {8'h1F, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h70, 8'h71};

    function automatic logic [6:0] div_of(input logic [2:0] c);
        return (c == 3'h7) ? 7'h00 : (7'h01 << c);
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // divider steps: waiting for a commit, then the commit itself
    sequence s_buf_wait;
        sh_db && !buffer_update;
    endsequence
    sequence s_buf_commit;
        sh_db && buffer_update;
    endsequence

    property p_unmapped;
        reg_rd && !mapped |=> reg_rvalid && (reg_addr != $past(reg_addr) || reg_rdata == 8'h00);
    endproperty
    property p_ref_ratio;
        reg_wr && reg_addr == 8'h1F |=> ref_divide_ratio ==
            (($past(reg_wdata[4:0]) == 5'h00) ? 6'h20 : {1'b0, $past(reg_wdata[4:0])});
    endproperty
    property p_feedback;
        reg_wr && reg_addr == 8'h24 |=> feedback_source == $past(reg_wdata[7]);
    endproperty
    property p_out_stage;
        reg_wr && reg_addr == 8'h25 |=> output_power_level == $past(reg_wdata[1:0])
            && {rf_output_enable, rf_out_pos_en, rf_out_neg_en} == {3{$past(reg_wdata[2])}};
    endproperty
    property p_pin_tristate;
        !sh_test[3] && sh_test[7:4] == 4'h0 && !spi_sdo_active |=> !test_pin_oe;
    endproperty
    property p_pin_serial;
        !sh_test[3] && (sh_test[7:4] != 4'h0 || spi_sdo_active)
            |=> test_pin_oe && test_pin_o == $past(spi_sdo);
    endproperty
    property p_pin_lock;
        sh_test[3] && sh_test[7:4] == 4'h1 |=> test_pin_oe && test_pin_o == $past(lock_detect);
    endproperty
    property p_div_direct;
        !sh_db |=> out_divide_ratio == div_of($past(sh_code));
    endproperty
    property p_div_held;
        s_buf_wait |=> $stable(out_divide_ratio);
    endproperty
    property p_div_commit;
        s_buf_commit |=> out_divide_ratio == div_of($past(sh_code));
    endproperty

    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio wrong");
    a_feedback: assert property (p_feedback) else $error("feedback source wrong");
    a_out_stage: assert property (p_out_stage) else $error("output stage wrong");
    a_pin_tristate: assert property (p_pin_tristate) else $error("pin not released");
    a_pin_serial: assert property (p_pin_serial) else $error("pin not serial data");
    a_pin_lock: assert property (p_pin_lock) else $error("pin not lock detect");
    a_div_direct: assert property (p_div_direct) else $error("divide ratio wrong");
    a_div_held: assert property (p_div_held) else $error("buffered ratio moved");
    a_div_commit: assert property (p_div_commit) else $error("commit ratio wrong");
endmodule

bind scrb_top scrb_chk u_chk (.*);
`default_nettype wire

// [tb_synth_config_register_bank.sv]
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// register bank testbench
// ************************************************************
module tb_synth_config_register_bank;
    logic       sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, src = 8'h00;
    logic       buffer_update = 1'b0, spi_sdo = 1'b0, spi_sdo_active = 1'b0;
    logic [7:0] reg_rdata, filter_coef0, filter_coef1;
    logic       reg_rvalid, test_pin_o, test_pin_oe, output_level_select, ref_input_mode;
    logic       ref_doubler_enable, ref_half_divide, filter_manual, feedback_source;
    logic       output_doubler_enable, rf_output_enable, rf_out_pos_en, rf_out_neg_en;
    logic [5:0] ref_divide_ratio;
    logic [6:0] out_divide_ratio;
    logic [1:0] output_power_level;
    int         fails = 0, checks = 0;
    // register table: address, reset value, readable bits
    logic [7:0] addrs [8] = '{8'h1F, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h70, 8'h71};
    logic [7:0] rsts  [8] = '{8'h01, 8'h14, 8'h00, 8'h00, 8'h80, 8'h07, 8'h00, 8'h00};
    logic [7:0] masks [8] = '{8'h1F, 8'hFC, 8'h70, 8'h32, 8'hF0, 8'hBF, 8'hFF, 8'hFF};
    logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};

    scrb_top dut (.*, .lock_detect(src[0]), .pump_up(src[1]), .pump_down(src[2]),
        .ref_div_half(src[3]), .fb_div_half(src[4]), .vco_test(src[5]),
        .cal_r_half(src[6]), .cal_n_half(src[7]));

    // free-running 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // address is held through the answer cycle because read data follows it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask

    // two edges after the write: one for registered outputs, one spare
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic report_and_stop;
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic [7:0] ref_exp(input logic [7:0] d);
        return (d[4:0] == 5'h00) ? 8'h20 : {3'h0, d[4:0]};
    endfunction

    function automatic logic [7:0] div_exp(input logic [2:0] c);
        return (c == 3'h7) ? 8'h00 : (8'h01 << c);
    endfunction

    // source order on src follows the select codes, code 8 is constant high
    function automatic logic pin_exp(input logic [3:0] c, input logic [7:0] s);
        if (c == 4'h8) return 1'b1;
        return (c < 4'h8) ? s[c - 4'h1] : s[c - 4'h3];
    endfunction

    // hang guard
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        report_and_stop;
    end

    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] s;
        d = $urandom(32'h00FE);
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(addrs[i], rsts[i]);
        check({2'h0, ref_divide_ratio}, 8'h01);
        check({1'b0, out_divide_ratio}, 8'h01);
        check({3'h0, feedback_source, rf_output_enable, rf_out_pos_en, output_power_level},
              8'h1F);
        for (int i = 0; i < 8; i++)
        begin
            wr(addrs[i], 8'hFF);
            rd(addrs[i], masks[i]);
            wr(addrs[i], 8'h00);
            rd(addrs[i], 8'h00);
        end
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        check({2'h0, ref_divide_ratio}, 8'h20);
        // random settings, buffering kept off so the divider follows at once
        repeat (24)
        begin
            d = 8'($urandom);
            wr(8'h1F, d);
            wr(8'h22, d);
            wr(8'h23, d);
            wr(8'h24, d);
            wr(8'h25, d & 8'hDF);
            wr(8'h70, d);
            wr(8'h71, ~d);
            settle;
            check({2'h0, ref_divide_ratio}, ref_exp(d));
            check({5'h0, ref_input_mode, ref_doubler_enable, ref_half_divide}, {5'h0, d[6:4]});
            check({7'h0, filter_manual}, {7'h0, d[1]});
            check({filter_coef0 ^ filter_coef1}, 8'hFF);
            check({7'h0, feedback_source}, {7'h0, d[7]});
            check({1'b0, out_divide_ratio}, div_exp(d[6:4]));
            check({2'h0, output_doubler_enable, rf_output_enable, rf_out_pos_en, rf_out_neg_en,
                   output_power_level}, {2'h0, d[3], {3{d[2]}}, d[1:0]});
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h24, {1'b1, 3'(c), 4'h0});
            settle;
            check({1'b0, out_divide_ratio}, div_exp(3'(c)));
        end
        // buffered divide: new code waits for the commit pulse
        wr(8'h24, 8'h80);
        wr(8'h25, 8'h27);
        wr(8'h24, 8'hB0);
        settle;
        check({1'b0, out_divide_ratio}, 8'h01);
        @(posedge sys_clk);
        buffer_update <= 1'b1;
        @(posedge sys_clk);
        buffer_update <= 1'b0;
        settle;
        check({1'b0, out_divide_ratio}, 8'h08);
        // shared pin: released, serial data, then each test source
        wr(8'h20, 8'h04);
        settle;
        check({7'h0, test_pin_oe}, 8'h00);
        @(posedge sys_clk);
        spi_sdo_active <= 1'b1;
        spi_sdo        <= 1'b1;
        wr(8'h20, 8'h84);
        settle;
        check({6'h0, test_pin_oe, test_pin_o}, 8'h03);
        for (int k = 0; k < 27; k++)
        begin
            s = 8'($urandom);
            @(posedge sys_clk);
            src     <= s;
            spi_sdo <= ~pin_exp(codes[k % 9], s);
            wr(8'h20, {codes[k % 9], 4'hC});
            settle;
            check({5'h0, output_level_select, test_pin_oe, test_pin_o},
                  {5'h0, 2'b11, pin_exp(codes[k % 9], s)});
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
